//--- core/dcad_bank.sv
// Register bank: alias views of twelve DMA channels on Avalon-MM
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps

module dcad_bank #(
    parameter int N_CHAN = dcad_pkg::N_CHAN
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [dcad_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [N_CHAN-1:0] chan_busy_out,
    output logic [N_CHAN-1:0] chan_xfer_out,
    output logic [N_CHAN-1:0] chan_irq_out
);

    // ========================================================
    // Address decode
    // Maps a byte address to channel, storage word and trigger flag
    function automatic dcad_pkg::dcad_dec_s decode(
        input logic [dcad_pkg::ADDR_W-1:0] addr
    );
        dcad_pkg::dcad_dec_s d;
        d.hit = (addr < dcad_pkg::BANK_END) && (addr[5:4] != 2'b00);
        d.chan = addr[9:6];
        d.trig = 1'b0;
        d.kind = dcad_pkg::DCAD_REG_CTRL;
        unique case ({addr[5:2], 2'b00})
            dcad_pkg::OFS_V1_CTRL: d.kind = dcad_pkg::DCAD_REG_CTRL;
            dcad_pkg::OFS_V1_SRC: d.kind = dcad_pkg::DCAD_REG_SRC;
            dcad_pkg::OFS_V1_DST: d.kind = dcad_pkg::DCAD_REG_DST;
            dcad_pkg::OFS_V1_CNT_TRIG:
            begin
                d.kind = dcad_pkg::DCAD_REG_CNT;
                d.trig = 1'b1;
            end
            dcad_pkg::OFS_V2_CTRL: d.kind = dcad_pkg::DCAD_REG_CTRL;
            dcad_pkg::OFS_V2_CNT: d.kind = dcad_pkg::DCAD_REG_CNT;
            dcad_pkg::OFS_V2_SRC: d.kind = dcad_pkg::DCAD_REG_SRC;
            dcad_pkg::OFS_V2_DST_TRIG:
            begin
                d.kind = dcad_pkg::DCAD_REG_DST;
                d.trig = 1'b1;
            end
            dcad_pkg::OFS_V3_CTRL: d.kind = dcad_pkg::DCAD_REG_CTRL;
            dcad_pkg::OFS_V3_DST: d.kind = dcad_pkg::DCAD_REG_DST;
            dcad_pkg::OFS_V3_CNT: d.kind = dcad_pkg::DCAD_REG_CNT;
            dcad_pkg::OFS_V3_SRC_TRIG:
            begin
                d.kind = dcad_pkg::DCAD_REG_SRC;
                d.trig = 1'b1;
            end
            default: d.hit = 1'b0; // Slots 0x00 to 0x0c below the first view are not mapped
        endcase
        return d;
    endfunction

    // Merges write data into an old word under byte enables
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ========================================================
    // Storage and state
    logic [31:0] ctrl_q [N_CHAN];
    logic [31:0] src_q [N_CHAN];
    logic [31:0] dst_q [N_CHAN];
    logic [31:0] cnt_q [N_CHAN];
    logic [31:0] work_q [N_CHAN];
    logic [N_CHAN-1:0] busy_q;
    logic [N_CHAN-1:0] xfer_q;
    logic [N_CHAN-1:0] irq_q;
    logic wait_q;
    logic [31:0] rdata_q;

    dcad_pkg::dcad_dec_s dec;
    logic wr_take;
    logic rd_lead;
    logic [31:0] old_word;
    logic [31:0] new_word;
    logic chan_ok;
    logic trig_wr;
    logic [N_CHAN-1:0] start_v;
    logic [N_CHAN-1:0] quiet_v;
    logic [31:0] load_val;

    // Decode of the held request and the word it touches
    always_comb
    begin
        dec = decode(avs_address_in);
        chan_ok = dec.hit && (32'(dec.chan) < N_CHAN);
        old_word = 32'h0000_0000;
        if (chan_ok)
        begin
            unique case (dec.kind)
                dcad_pkg::DCAD_REG_CTRL: old_word = ctrl_q[dec.chan];
                dcad_pkg::DCAD_REG_SRC: old_word = src_q[dec.chan];
                dcad_pkg::DCAD_REG_DST: old_word = dst_q[dec.chan];
                dcad_pkg::DCAD_REG_CNT: old_word = cnt_q[dec.chan];
            endcase
        end
        new_word = merge(old_word, avs_writedata_in, avs_byteenable_in);
    end

    // Write takes effect at the edge where waitrequest is low
    assign wr_take = avs_write_in && !wait_q;
    assign rd_lead = avs_read_in && wait_q;
    assign trig_wr = wr_take && chan_ok && dec.trig;

    // Start and quiet-interrupt requests per channel
    always_comb
    begin
        start_v = '0;
        quiet_v = '0;
        load_val = cnt_q[0];
        if (chan_ok)
        begin
            load_val = cnt_q[dec.chan];
            if (dec.kind == dcad_pkg::DCAD_REG_CNT)
            begin
                load_val = new_word; // Count trigger reloads the new count
            end
        end
        for (int c = 0; c < N_CHAN; c++)
        begin
            if (trig_wr && (32'(dec.chan) == c))
            begin
                // Nonzero write with enable set starts the channel
                start_v[c] = (new_word != 32'h0000_0000) &&
                    ctrl_q[c][dcad_pkg::CTRL_EN_BIT];
                // Zero write in quiet mode flags the end of a chain
                quiet_v[c] = (new_word == 32'h0000_0000) &&
                    ctrl_q[c][dcad_pkg::CTRL_QUIET_BIT];
            end
        end
    end

    // ========================================================
    // Avalon-MM slave handshake: one wait cycle per access
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= !((avs_read_in || avs_write_in) && wait_q);
        end
    end

    // Read data captured in the wait cycle, held for the answer
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdata_q <= dcad_pkg::UNMAPPED_READ;
        end
        else if (rd_lead)
        begin
            rdata_q <= chan_ok ? old_word : dcad_pkg::UNMAPPED_READ;
        end
    end

    // ========================================================
    // Shared storage: every view lands on the same word
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            for (int c = 0; c < N_CHAN; c++)
            begin
                ctrl_q[c] <= dcad_pkg::CTRL_RESET;
                ctrl_q[c][dcad_pkg::CTRL_CHAIN_LSB +: 4] <= 4'(c);
                src_q[c] <= dcad_pkg::PTR_RESET;
                dst_q[c] <= dcad_pkg::PTR_RESET;
                cnt_q[c] <= dcad_pkg::CNT_RESET;
            end
        end
        else if (wr_take && chan_ok)
        begin
            unique case (dec.kind)
                dcad_pkg::DCAD_REG_CTRL: ctrl_q[dec.chan] <= new_word;
                dcad_pkg::DCAD_REG_SRC: src_q[dec.chan] <= new_word;
                dcad_pkg::DCAD_REG_DST: dst_q[dec.chan] <= new_word;
                dcad_pkg::DCAD_REG_CNT: cnt_q[dec.chan] <= new_word;
            endcase
        end
    end

    // ========================================================
    // Channel run state: reload, count down, finish
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            for (int c = 0; c < N_CHAN; c++)
            begin
                work_q[c] <= dcad_pkg::CNT_RESET;
            end
            busy_q <= '0;
            xfer_q <= '0;
            irq_q <= '0;
        end
        else
        begin
            for (int c = 0; c < N_CHAN; c++)
            begin
                xfer_q[c] <= 1'b0;
                irq_q[c] <= quiet_v[c];
                if (start_v[c])
                begin
                    work_q[c] <= load_val;
                    busy_q[c] <= 1'b1;
                end
                else if (busy_q[c] && ctrl_q[c][dcad_pkg::CTRL_EN_BIT])
                begin
                    // Disabled channels pause here with the count held
                    if (work_q[c] == 32'h0000_0000)
                    begin
                        busy_q[c] <= 1'b0;
                        // A quiet zero write in the same cycle still wins
                        irq_q[c] <= quiet_v[c] ||
                            !ctrl_q[c][dcad_pkg::CTRL_QUIET_BIT];
                    end
                    else
                    begin
                        work_q[c] <= work_q[c] - 32'h0000_0001;
                        xfer_q[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // Outputs straight from flip-flops
    assign avs_waitrequest_out = wait_q;
    assign avs_readdata_out = rdata_q;
    assign chan_busy_out = busy_q;
    assign chan_xfer_out = xfer_q;
    assign chan_irq_out = irq_q;

    // ========================================================
    // Checks
    sequence s_req_wait;
        (avs_read_in || avs_write_in) && wait_q;
    endsequence

    sequence s_answer;
        !wait_q ##1 wait_q;
    endsequence

    handshake_answer_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in) s_req_wait |=> s_answer)
        else $error("access not answered after one wait cycle");

    alias_store_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        wr_take && chan_ok && dec.kind == dcad_pkg::DCAD_REG_CTRL
        |=> ctrl_q[$past(dec.chan)] == $past(new_word))
        else $error("control write not stored");

    alias_readback_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        !wait_q && avs_read_in && chan_ok |-> rdata_q == old_word)
        else $error("read data differs from stored word");

    unmapped_read_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        !wait_q && avs_read_in && !chan_ok
        |-> rdata_q == dcad_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");

    trigger_start_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        (|start_v) |=> ((busy_q & $past(start_v)) == $past(start_v))
        && work_q[$past(dec.chan)] == $past(load_val))
        else $error("trigger did not reload and start");

    plain_no_start_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        wr_take && chan_ok && !dec.trig |-> start_v == '0)
        else $error("plain alias write started a channel");

    zero_no_start_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        trig_wr && new_word == 32'h0000_0000 && !busy_q[dec.chan]
        |=> !busy_q[$past(dec.chan)])
        else $error("zero trigger write started a channel");

    quiet_irq_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        trig_wr && new_word == 32'h0000_0000
        && ctrl_q[dec.chan][dcad_pkg::CTRL_QUIET_BIT]
        |=> chan_irq_out[$past(dec.chan)]
        ##1 !chan_irq_out[$past(dec.chan, 2)])
        else $error("quiet zero write gave no one-cycle interrupt");

    disabled_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        busy_q[0] && !ctrl_q[0][dcad_pkg::CTRL_EN_BIT] && !start_v[0]
        |=> busy_q[0] && work_q[0] == $past(work_q[0]) && !xfer_q[0])
        else $error("disabled channel kept transferring");

    disabled_trig_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        trig_wr && !ctrl_q[dec.chan][dcad_pkg::CTRL_EN_BIT]
        && !busy_q[dec.chan] |=> !busy_q[$past(dec.chan)])
        else $error("disabled channel accepted a trigger");

    // Channel 0 stands for all channels in the run-state checks
    sequence s_run_step0;
        busy_q[0] && ctrl_q[0][dcad_pkg::CTRL_EN_BIT] && !start_v[0];
    endsequence

    count_step_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        s_run_step0 ##0 (work_q[0] != 32'h0000_0000)
        |=> xfer_q[0] && (work_q[0] == $past(work_q[0]) - 32'h0000_0001))
        else $error("running channel did not step its count");

    end_irq_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        s_run_step0 ##0 (work_q[0] == 32'h0000_0000 && !quiet_v[0])
        |=> !busy_q[0]
        && (chan_irq_out[0] == !$past(ctrl_q[0][dcad_pkg::CTRL_QUIET_BIT])))
        else $error("finished channel gave the wrong interrupt");

    quiet_end_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        (|quiet_v) |=> ((chan_irq_out & $past(quiet_v)) == $past(quiet_v)))
        else $error("quiet interrupt lost");

    xfer_busy_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        (chan_xfer_out & ~chan_busy_out) == '0)
        else $error("transfer pulse from an idle channel");

    rdata_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (!resetn_in)
        !rd_lead |=> $stable(rdata_q))
        else $error("read data changed without a read");

endmodule

//--- core/dcad_pkg.sv
// Package for the DMA channel alias decode register bank
package dcad_pkg;
    // ========================================================
    // Geometry of the channel groups
    localparam int N_CHAN = 12;
    localparam int ADDR_W = 10;
    localparam logic [9:0] GROUP_STRIDE = 10'h040;
    localparam logic [9:0] BANK_END = 10'h300;
    // ========================================================
    // Offsets within a channel group (low six address bits)
    localparam logic [5:0] OFS_V1_CTRL = 6'h10;
    localparam logic [5:0] OFS_V1_SRC = 6'h14;
    localparam logic [5:0] OFS_V1_DST = 6'h18;
    localparam logic [5:0] OFS_V1_CNT_TRIG = 6'h1c;
    localparam logic [5:0] OFS_V2_CTRL = 6'h20;
    localparam logic [5:0] OFS_V2_CNT = 6'h24;
    localparam logic [5:0] OFS_V2_SRC = 6'h28;
    localparam logic [5:0] OFS_V2_DST_TRIG = 6'h2c;
    localparam logic [5:0] OFS_V3_CTRL = 6'h30;
    localparam logic [5:0] OFS_V3_DST = 6'h34;
    localparam logic [5:0] OFS_V3_CNT = 6'h38;
    localparam logic [5:0] OFS_V3_SRC_TRIG = 6'h3c;
    // ========================================================
    // Control register fields and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_QUIET_BIT = 21;
    localparam int CTRL_CHAIN_LSB = 11;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // ========================================================
    // Channel storage selected by a decoded access
    typedef enum logic [1:0] {
        DCAD_REG_CTRL,
        DCAD_REG_SRC,
        DCAD_REG_DST,
        DCAD_REG_CNT
    } dcad_reg_e;
    // Result of one address decode
    typedef struct packed {
        logic hit;
        logic [3:0] chan;
        dcad_reg_e kind;
        logic trig;
    } dcad_dec_s;
endpackage

//--- sim/dcad_bank_bench.sv
// Self-checking testbench for the DMA channel alias decode register bank
`timescale 1ns/1ps

module dcad_bank_bench;
    // ========================================================
    // Bus, channel and bookkeeping signals
    logic ref_clk_in;
    logic resetn_in;
    logic [9:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [11:0] chan_busy;
    logic [11:0] chan_xfer;
    logic [11:0] chan_irq;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int xfer_tot = 0;
    int irq_tot = 0;
    // Views of control, source, destination and count; trigger last
    localparam logic [5:0] OFS_TAB [4][3] = '{'{6'h10, 6'h20, 6'h30},
        '{6'h14, 6'h28, 6'h3c}, '{6'h18, 6'h34, 6'h2c},
        '{6'h24, 6'h38, 6'h1c}};
    localparam logic [5:0] TRG_TAB [3] = '{6'h1c, 6'h2c, 6'h3c};

    dcad_bank #(.N_CHAN(12)) DUT (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .avs_address_in(avs_address),
        .avs_read_in(avs_read),
        .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(avs_byteenable),
        .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest),
        .chan_busy_out(chan_busy),
        .chan_xfer_out(chan_xfer),
        .chan_irq_out(chan_irq)
    );

    // ========================================================
    // Clock, pulse tallies and hang guard
    initial
    begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // Tally every transfer and interrupt pulse over all channels
    always @(posedge ref_clk_in)
    begin
        xfer_tot <= xfer_tot + $countones(chan_xfer);
        irq_tot <= irq_tot + $countones(chan_irq);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // ========================================================
    // Shared tasks
    task automatic close_out();
        $display("counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [9:0] adr(input int ch, input logic [5:0] ofs);
        return 10'(ch * 64) + {4'h0, ofs};
    endfunction

    // Write held until waitrequest is sampled low
    task automatic wr(input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        @(posedge ref_clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        @(posedge ref_clk_in iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
    endtask

    // Read held until waitrequest is sampled low; data taken there
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge ref_clk_in iff avs_waitrequest === 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    // Trigger write, then busy and pulse counts over the next cycles
    task automatic trig(input int ch, input logic [5:0] ofs,
                        input logic [31:0] d, input logic bsy,
                        input int nx, input int ni);
        int x0;
        int i0;
        x0 = xfer_tot;
        i0 = irq_tot;
        wr(adr(ch, ofs), d, 4'hf);
        @(posedge ref_clk_in);
        chk("busy after trigger", 32'(chan_busy[ch]), 32'(bsy));
        repeat (8) @(posedge ref_clk_in);
        chk("busy at end", 32'(chan_busy[ch]), 32'h0000_0000);
        chk("transfer pulses", 32'(xfer_tot - x0), 32'(nx));
        chk("interrupt pulses", 32'(irq_tot - i0), 32'(ni));
    endtask

    // ========================================================
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [31:0] v;
        int xs;
        int ys;
        resetn_in = 1'b0;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        repeat (6) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        // Reset control and count of every channel through rotating views
        for (int ch = 0; ch < 12; ch++)
        begin
            rd(adr(ch, OFS_TAB[0][ch % 3]), d);
            chk("control reset", d, 32'(ch) << 11);
            rd(adr(ch, OFS_TAB[3][ch % 3]), d);
            chk("count reset", d, 32'h0000_0000);
        end
        $display("test reset values done");
        // Write each plain view, read back through all three views
        xs = xfer_tot;
        for (int k = 0; k < 4; k++)
            for (int w = 0; w < ((k == 0) ? 3 : 2); w++)
            begin
                d = 32'ha5a0_0000 | 32'(k << 8) | 32'(w << 4) | 32'(k == 0);
                wr(adr(5, OFS_TAB[k][w]), d, 4'hf);
                for (int r = 0; r < 3; r++)
                begin
                    rd(adr(5, OFS_TAB[k][r]), v);
                    chk("alias readback", v, d);
                end
            end
        chk("plain view busy", 32'(chan_busy[5]), 32'h0000_0000);
        chk("plain view xfer", 32'(xfer_tot - xs), 32'h0000_0000);
        $display("test alias views done");
        // Byte lanes, unmapped slots and the end of the bank
        wr(adr(0, 6'h14), 32'h0000_0000, 4'hf);
        wr(adr(0, 6'h14), 32'hffff_ffff, 4'h1);
        wr(adr(0, 6'h14), 32'hffff_ffff, 4'h4);
        rd(adr(0, 6'h28), d);
        chk("byte lanes", d, 32'h00ff_00ff);
        wr(adr(1, 6'h00), 32'h1234_5678, 4'hf);
        rd(adr(1, 6'h00), d);
        chk("unmapped slot", d, 32'h0000_0000);
        rd(adr(1, 6'h10), d);
        chk("channel 1 control", d, 32'h0000_0800);
        rd(10'h300, d);
        chk("past bank end", d, 32'h0000_0000);
        $display("test decode edges done");
        // Each trigger view starts its channel, up to channel 11
        for (int t = 0; t < 3; t++)
        begin
            v = (t == 0) ? 32'h0000_0002 : 32'h2000_0100;
            wr(adr(9 + t, 6'h10), (32'(9 + t) << 11) | 32'h0000_0001, 4'hf);
            wr(adr(9 + t, 6'h24), 32'h0000_0003, 4'hf);
            trig(9 + t, TRG_TAB[t], v, 1'b1, t ? 3 : 2, 1);
            rd(adr(9 + t, TRG_TAB[t]), d);
            chk("trigger word stored", d, v);
        end
        $display("test trigger views done");
        // Zero trigger writes, then quiet mode
        wr(adr(4, 6'h10), 32'h0000_2001, 4'hf);
        for (int t = 0; t < 3; t++)
            trig(4, TRG_TAB[t], 32'h0000_0000, 1'b0, 0, 0);
        wr(adr(4, 6'h20), 32'h0020_2001, 4'hf);
        trig(4, 6'h2c, 32'h0000_0000, 1'b0, 0, 1);
        trig(4, 6'h1c, 32'h0000_0002, 1'b1, 2, 0);
        $display("test zero and quiet done");
        // Enable clear ignores a nonzero trigger
        wr(adr(6, 6'h30), 32'h0000_3000, 4'hf);
        trig(6, 6'h1c, 32'h0000_0005, 1'b0, 0, 0);
        $display("test enable clear done");
        // Clearing enable pauses a busy channel; setting it resumes
        xs = xfer_tot;
        ys = irq_tot;
        wr(adr(0, 6'h10), 32'h0000_0001, 4'hf);
        wr(adr(0, 6'h1c), 32'h0000_0006, 4'hf);
        wr(adr(0, 6'h30), 32'h0000_0000, 4'hf);
        repeat (4) @(posedge ref_clk_in);
        chk("paused busy", 32'(chan_busy[0]), 32'h0000_0001);
        chk("paused pulses", 32'(xfer_tot - xs), 32'h0000_0003);
        wr(adr(0, 6'h20), 32'h0000_0001, 4'hf);
        repeat (8) @(posedge ref_clk_in);
        chk("resumed busy", 32'(chan_busy[0]), 32'h0000_0000);
        chk("resumed pulses", 32'(xfer_tot - xs), 32'h0000_0006);
        chk("resumed interrupt", 32'(irq_tot - ys), 32'h0000_0001);
        $display("test enable pause done");
        close_out();
    end
endmodule
